/* File: rtl/symbol_period_gen.sv */
// free-running symbol period generator: one strobe every period ticks
// assumes one tick per ref_clk cycle and a period input from same-clock registers
`default_nettype none
module symbol_period_gen #(
   parameter int PERIOD_W = 9
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [PERIOD_W-1:0] period,
   output logic strobe
);
   logic [PERIOD_W-1:0] count_r, count_nxt;
   logic strobe_r, strobe_nxt;
   logic wrap;

   // a period of 0 or 1 wraps every tick rather than hanging the counter
   always_comb begin
      wrap = ({1'b0, count_r} + {{PERIOD_W{1'b0}}, 1'b1}) >= {1'b0, period};
      count_nxt = wrap ? '0 : count_r + {{(PERIOD_W-1){1'b0}}, 1'b1}; // RL2
      strobe_nxt = wrap; // RL1
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= '0;
         strobe_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         strobe_r <= strobe_nxt;
      end
   end

   assign strobe = strobe_r;

   // helper logic: cycles between strobes, and whether the period moved in between
   logic [PERIOD_W:0] gap_r;
   logic [PERIOD_W-1:0] period_q_r;
   logic chg_r;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         gap_r <= '0;
         period_q_r <= '0;
         chg_r <= 1'b1;
      end else begin
         gap_r <= strobe_r ? {{PERIOD_W{1'b0}}, 1'b1} : gap_r + {{PERIOD_W{1'b0}}, 1'b1};
         period_q_r <= period;
         chg_r <= strobe_r ? 1'b0 : (chg_r | (period_q_r != period));
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   tick_rate_a: assert property (!wrap |=> count_r == $past(count_r) + 1'b1) // RL2
      else $error("tick counter did not advance by one");
   period_wrap_a: assert property ((strobe_r && !chg_r && period > 1 && period_q_r == period) // RL1
         |-> gap_r == {1'b0, period})
      else $error("symbol strobe spacing differs from period");
   period_seen_c: cover property (strobe_r ##1 !strobe_r [*3]);
endmodule
`default_nettype wire

/* File: rtl/tx_pa_enable_lead_timer.sv */
// transmit and power amplifier enable lead timer with apb register slave
// assumes tx_req and tx_done come from same-clock logic; one tick equals one ref_clk cycle
// Operation
// (RL1) symbol period is programmable tick count, 0x140
// (RL2) one tick per system clock cycle
// (RL3) period count: low byte plus high bit 0
// (RL4) tx enable leads by tick count, 0x028
// (RL5) tx ticks from high reg 7-1, reg2 1:0
// (RL6) amp enable leads by tick count, 0x029
// (RL7) amp lead symbols bits 4-1, min 1
// (RL8) software writes zero to amp bits 7-5
// (RL9) tx lead symbols: min 1, default 2
// (RL10) lead equals symbols times period plus ticks
`default_nettype none
module tx_pa_enable_lead_timer (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_req,
   input wire logic tx_done,
   output logic tx_en,
   output logic pa_en,
   output logic pkt_start,
   output logic symbol_strobe
);
   logic [7:0] regs_r [lead_timer_pkg::NUM_REGS];
   logic [7:0] regs_nxt [lead_timer_pkg::NUM_REGS];
   localparam logic [7:0] REG_RST [lead_timer_pkg::NUM_REGS] = '{lead_timer_pkg::RST_SLOT_END,
      lead_timer_pkg::RST_SYM_LOW, lead_timer_pkg::RST_SYM_HIGH, lead_timer_pkg::RST_AMP0,
      lead_timer_pkg::RST_AMP1, lead_timer_pkg::RST_AMP2};

   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic access, hit, wr_take;
   logic [5:0] idx;
   logic [7:0] rd_byte, status;

   lead_timer_pkg::sched_state_t state_r, state_nxt;
   logic [lead_timer_pkg::TOTAL_W-1:0] remain_r, remain_nxt, tx_tot_r, tx_tot_nxt, pa_tot_r, pa_tot_nxt;
   logic tx_en_r, tx_en_nxt, pa_en_r, pa_en_nxt, start_r, start_nxt;
   logic [8:0] sym_period;
   lead_timer_pkg::lead_cfg_t tx_cfg, pa_cfg;
   logic [lead_timer_pkg::TOTAL_W-1:0] tx_total, pa_total;
   logic sym_strobe_w, sym_strobe_r;

   // apb decode; answer comes one cycle into the access phase so pready is a flop
   always_comb begin
      idx = paddr[7:2];
      access = psel & penable;
      hit = (idx >= lead_timer_pkg::IDX_SLOT_END) && (idx <= lead_timer_pkg::IDX_STATUS);
      wr_take = access & pready_r & pwrite & hit & (idx != lead_timer_pkg::IDX_STATUS);
      status = 8'h00;
      status[lead_timer_pkg::ST_BUSY_BIT] = (state_r != lead_timer_pkg::ST_IDLE);
      status[lead_timer_pkg::ST_TXEN_BIT] = tx_en_r;
      status[lead_timer_pkg::ST_PAEN_BIT] = pa_en_r;
      if (idx == lead_timer_pkg::IDX_STATUS) begin
         rd_byte = status;
      end else if (hit) begin
         rd_byte = regs_r[3'(idx - lead_timer_pkg::IDX_SLOT_END)];
      end else begin
         rd_byte = 8'h00;
      end
      pready_nxt = access & ~pready_r;
      pslverr_nxt = access & ~pready_r & ~hit;
      prdata_nxt = (access & ~pready_r & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
   end

   // register file; a write lands at the edge where pready is sampled high
   always_comb begin
      for (int i = 0; i < lead_timer_pkg::NUM_REGS; i++) begin
         regs_nxt[i] = regs_r[i];
         if (wr_take && idx == 6'(i) + lead_timer_pkg::IDX_SLOT_END) begin
            regs_nxt[i] = pwdata[7:0];
         end
      end
      // reserved bits are forced low so a careless write cannot disturb them
      regs_nxt[4] = regs_nxt[4] & lead_timer_pkg::AMP1_WR_MASK; // RL8
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < lead_timer_pkg::NUM_REGS; i++) begin
            regs_r[i] <= REG_RST[i];
         end
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         regs_r <= regs_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // field assembly from the byte registers; a zero symbol count is raised to the minimum
   always_comb begin
      sym_period = {regs_r[2][0], regs_r[1]}; // RL3
      tx_cfg.ticks = {regs_r[5][1:0], regs_r[2][7:1]}; // RL5
      tx_cfg.symbols = (regs_r[5][5:2] < lead_timer_pkg::SYM_MIN) ? lead_timer_pkg::SYM_MIN : regs_r[5][5:2]; // RL9
      pa_cfg.ticks = {regs_r[4][0], regs_r[3]}; // RL6
      pa_cfg.symbols = (regs_r[4][4:1] < lead_timer_pkg::SYM_MIN) ? lead_timer_pkg::SYM_MIN : regs_r[4][4:1]; // RL7
      tx_total = 14'(14'(tx_cfg.symbols) * 14'(sym_period)) + 14'(tx_cfg.ticks); // RL10
      pa_total = 14'(14'(pa_cfg.symbols) * 14'(sym_period)) + 14'(pa_cfg.ticks); // RL10
   end

   symbol_period_gen #(
      .PERIOD_W(9)
   ) symbol_period_gen_i (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .period(sym_period),
      .strobe(sym_strobe_w)
   );

   // scheduler: count down from the longer lead; each enable rises when the count meets its own lead
   always_comb begin
      state_nxt = state_r;
      remain_nxt = remain_r;
      tx_tot_nxt = tx_tot_r;
      pa_tot_nxt = pa_tot_r;
      tx_en_nxt = tx_en_r;
      pa_en_nxt = pa_en_r;
      start_nxt = 1'b0;
      case (state_r)
         lead_timer_pkg::ST_IDLE: begin
            // totals are frozen at the request so register writes cannot bend a lead in flight
            if (tx_req) begin
               tx_tot_nxt = tx_total;
               pa_tot_nxt = pa_total;
               remain_nxt = (tx_total > pa_total) ? tx_total : pa_total;
               state_nxt = lead_timer_pkg::ST_LEAD;
            end
         end
         lead_timer_pkg::ST_LEAD: begin
            tx_en_nxt = tx_en_r | (remain_r <= tx_tot_r); // RL4
            pa_en_nxt = pa_en_r | (remain_r <= pa_tot_r); // RL6
            if (remain_r == '0) begin
               start_nxt = 1'b1;
               state_nxt = lead_timer_pkg::ST_SEND;
            end else begin
               remain_nxt = remain_r - 14'h0001;
            end
         end
         lead_timer_pkg::ST_SEND: begin
            if (tx_done) begin
               tx_en_nxt = 1'b0;
               pa_en_nxt = 1'b0;
               state_nxt = lead_timer_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = lead_timer_pkg::ST_IDLE;
            tx_en_nxt = 1'b0;
            pa_en_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= lead_timer_pkg::ST_IDLE;
         remain_r <= '0;
         tx_tot_r <= '0;
         pa_tot_r <= '0;
         tx_en_r <= 1'b0;
         pa_en_r <= 1'b0;
         start_r <= 1'b0;
         sym_strobe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         remain_r <= remain_nxt;
         tx_tot_r <= tx_tot_nxt;
         pa_tot_r <= pa_tot_nxt;
         tx_en_r <= tx_en_nxt;
         pa_en_r <= pa_en_nxt;
         start_r <= start_nxt;
         sym_strobe_r <= sym_strobe_w;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_en = tx_en_r;
   assign pa_en = pa_en_r;
   assign pkt_start = start_r;
   assign symbol_strobe = sym_strobe_r;

   // helper logic: cycles each enable has been high before the packet start
   logic [lead_timer_pkg::TOTAL_W-1:0] tx_age_r, pa_age_r;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_age_r <= '0;
         pa_age_r <= '0;
      end else if (state_r == lead_timer_pkg::ST_IDLE) begin
         tx_age_r <= '0;
         pa_age_r <= '0;
      end else if (state_r == lead_timer_pkg::ST_LEAD) begin
         tx_age_r <= tx_age_r + 14'(tx_en_r);
         pa_age_r <= pa_age_r + 14'(pa_en_r);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   period_field_a: assert property (sym_period == {regs_r[2][0], regs_r[1]}) // RL3
      else $error("symbol period not assembled from low byte and high bit");
   tx_field_a: assert property (tx_cfg.ticks == {regs_r[5][1:0], regs_r[2][7:1]}) // RL5
      else $error("tx lead ticks not assembled correctly");
   tx_lead_time_a: assert property ($rose(start_r) |-> tx_age_r == tx_tot_r && tx_en_r) // RL4
      else $error("tx enable lead differs from programmed total");
   amp_lead_time_a: assert property ($rose(start_r) |-> pa_age_r == pa_tot_r && pa_en_r) // RL6
      else $error("amp enable lead differs from programmed total");
   lead_total_a: assert property ((state_r == lead_timer_pkg::ST_IDLE && tx_req) // RL10
         |=> tx_tot_r == $past(tx_cfg.symbols) * $past(sym_period) + $past(tx_cfg.ticks))
      else $error("tx total is not symbols times period plus ticks");
   // a zero symbol field must still buy at least one whole symbol of lead
   amp_symbol_min_a: assert property ((state_r == lead_timer_pkg::ST_IDLE && tx_req) // RL7
         |=> pa_tot_r >= 14'($past(sym_period)) && tx_tot_r >= 14'($past(sym_period)))
      else $error("symbol lead below one period");
   reserved_zero_a: assert property (regs_r[4][7:5] == 3'b000) // RL8
      else $error("amp reserved bits not zero");
   enables_hold_a: assert property ((state_r == lead_timer_pkg::ST_SEND && !tx_done) |=> tx_en_r && pa_en_r) // RL10
      else $error("enable dropped before transmit done");
   apb_answer_a: assert property ((psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
      else $error("apb answer not a single cycle after access");

   lead_c: cover property ($rose(tx_en_r) ##[1:1000] start_r);
   amp_first_c: cover property ($rose(pa_en_r) && !tx_en_r);
   done_c: cover property (state_r == lead_timer_pkg::ST_SEND && tx_done);
   bad_addr_c: cover property (pslverr_r);
endmodule
`default_nettype wire

/* File: shared/lead_timer_pkg.sv */
// package for the transmit / amplifier lead timer: register indices, reset values, field types
// assumes registers are reached over apb, one aligned 32-bit word per register (byte address = index * 4)
`default_nettype none
package lead_timer_pkg;
   // printed offsets are register indices; apb byte address is index * 4
   localparam logic [5:0] IDX_SLOT_END = 6'h13;
   localparam logic [5:0] IDX_SYM_LOW = 6'h14;
   localparam logic [5:0] IDX_SYM_HIGH = 6'h15;
   localparam logic [5:0] IDX_AMP0 = 6'h16;
   localparam logic [5:0] IDX_AMP1 = 6'h17;
   localparam logic [5:0] IDX_AMP2 = 6'h18;
   localparam logic [5:0] IDX_STATUS = 6'h19;
   localparam int NUM_REGS = 6;
   // power-on values: symbol period 0x140, tx ticks 0x028, amp ticks 0x029, amp symbols 1, tx symbols 2
   localparam logic [7:0] RST_SLOT_END = 8'h00;
   localparam logic [7:0] RST_SYM_LOW = 8'h40;
   localparam logic [7:0] RST_SYM_HIGH = 8'h51;
   localparam logic [7:0] RST_AMP0 = 8'h29;
   localparam logic [7:0] RST_AMP1 = 8'h02;
   localparam logic [7:0] RST_AMP2 = 8'h88;
   // writable bits of amp_control_reg_1; bits 7-5 are reserved and held at zero
   localparam logic [7:0] AMP1_WR_MASK = 8'h1F;
   localparam logic [3:0] SYM_MIN = 4'h1;
   localparam int TOTAL_W = 14;
   // status register bit positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_TXEN_BIT = 1;
   localparam int ST_PAEN_BIT = 2;

   typedef struct packed {
      logic [3:0] symbols;
      logic [8:0] ticks;
   } lead_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_SEND = 3'b100
   } sched_state_t;
endpackage
`default_nettype wire

/* File: verif/rf_front_model.sv */
// rf front-end stand-in: measures how long each enable leads the first symbol, then ends the packet
// assumes enables and packet start are registered outputs on the same ref_clk
`default_nettype none
module rf_front_model #(
   parameter int HOLD = 3
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic tx_en,
   input wire logic pa_en,
   input wire logic pkt_start,
   output logic tx_done,
   output logic [15:0] tx_lead,
   output logic [15:0] pa_lead
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] tx_cnt_r;
   logic [15:0] pa_cnt_r;
   int hold_cnt;
   // count cycles each enable stands before the first symbol; a real front end needs that settling time
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_cnt_r <= 16'h0000;
         pa_cnt_r <= 16'h0000;
         tx_lead <= 16'h0000;
         pa_lead <= 16'h0000;
         tx_done <= 1'b0;
         hold_cnt <= 0;
      end else begin
         tx_cnt_r <= (tx_en && !pkt_start) ? tx_cnt_r + 16'h0001 : 16'h0000;
         pa_cnt_r <= (pa_en && !pkt_start) ? pa_cnt_r + 16'h0001 : 16'h0000;
         if (pkt_start) begin
            tx_lead <= tx_cnt_r;
            pa_lead <= pa_cnt_r;
         end
         // packet ends a fixed time after its first symbol, with a one-cycle done pulse
         tx_done <= (hold_cnt == 1);
         if (pkt_start)
            hold_cnt <= HOLD;
         else if (hold_cnt > 0)
            hold_cnt <= hold_cnt - 1;
      end
   end
endmodule
`default_nettype wire

/* File: verif/tb_tx_pa_enable_lead_timer.sv */
// testbench for the lead timer: apb register tasks plus lead sequences measured by the front-end model
// assumes a 25 MHz ref_clk and a slave answering with its own pready
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("FAIL t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_tx_pa_enable_lead_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rstn, psel, penable, pwrite, tx_req, tx_done, tx_en, pa_en, pkt_start, symbol_strobe;
   logic pready, pslverr, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] tx_lead, pa_lead;
   int err_total = 0;
   int num_checks = 0;
   // registers 0x14..0x18 per case: short period, 9-bit period, zero symbol fields clamped to one
   logic [7:0] cfg [3][5] = '{'{8'h04, 8'h06, 8'h05, 8'h02, 8'h18},
      '{8'h02, 8'h01, 8'h10, 8'h03, 8'h06}, '{8'h03, 8'h02, 8'h02, 8'h00, 8'h00}};
   int per [3] = '{4, 258, 3};
   int exp_tx [3] = '{27, 514, 4};
   int exp_pa [3] = '{9, 530, 5};

   always #20 ref_clk = ~ref_clk;

   tx_pa_enable_lead_timer tx_pa_enable_lead_timer_i (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_req(tx_req), .tx_done(tx_done), .tx_en(tx_en), .pa_en(pa_en),
      .pkt_start(pkt_start), .symbol_strobe(symbol_strobe));
   rf_front_model #(.HOLD(3)) rf_front_model_i (.ref_clk(ref_clk), .rstn(rstn), .tx_en(tx_en), .pa_en(pa_en),
      .pkt_start(pkt_start), .tx_done(tx_done), .tx_lead(tx_lead), .pa_lead(pa_lead));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] rd,
      output logic err);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         err_total++;
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic e;
      apb(idx, 1'b0, 8'h00, d, e);
      `CHK(d, {24'h000000, exp})
      `CHK(e, 1'b0)
   endtask

   // distance between two symbol strobes; the first one after a change may still use the old period
   task automatic chk_period(input int p);
      int n;
      n = 0;
      // sample only after an edge has settled, never the stale value of the call's own edge
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (symbol_strobe !== 1'b1 && n < 600);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (symbol_strobe !== 1'b1 && n < 600);
      `CHK(n, p)
   endtask

   // one request pulse; enables must stand until done, then drop together
   task automatic run_seq(input int ttx, input int tpa);
      int n;
      n = 0;
      @(posedge ref_clk) tx_req <= 1'b1;
      @(posedge ref_clk) tx_req <= 1'b0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (pkt_start !== 1'b1 && n < 2000);
      `CHK(n, ((ttx > tpa) ? ttx : tpa) + 1)
      // the model raises done four edges after the start; enables stand through that cycle
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK({tx_en, pa_en}, 2'b11)
      @(posedge ref_clk);
      #1;
      `CHK({tx_en, pa_en}, 2'b00)
      `CHK(tx_lead, 16'(ttx))
      `CHK(pa_lead, 16'(tpa))
   endtask

   initial begin
      repeat (10000) @(posedge ref_clk);
      err_total++;
      tally_and_finish;
   end

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      tx_req = 1'b0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      // power-on values
      rd_chk(6'h13, 8'h00);
      rd_chk(6'h14, 8'h40);
      rd_chk(6'h15, 8'h51);
      rd_chk(6'h16, 8'h29);
      rd_chk(6'h17, 8'h02);
      rd_chk(6'h18, 8'h88);
      rd_chk(6'h19, 8'h00);
      // unmapped index answers with an error and zero data
      apb(6'h3F, 1'b0, 8'h00, rdat, rerr);
      `CHK({rerr, rdat}, 33'h100000000)
      for (int k = 0; k < 3; k++) begin
         for (int r = 0; r < 5; r++)
            apb(6'h14 + 6'(r), 1'b1, cfg[k][r], rdat, rerr);
         for (int r = 0; r < 5; r++)
            rd_chk(6'h14 + 6'(r), cfg[k][r]);
         chk_period(per[k]);
         run_seq(exp_tx[k], exp_pa[k]);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
